/* hdl/rta_top.sv */
// Temperature alarm, trip, grouping and voting evaluation for the remote sensor link
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "rta_regs.svh"

module rta_top #(
   parameter int unsigned TICK_CYC  = `RTA_CLK_HZ / 1000000 * `RTA_TICK_US,
   parameter int unsigned TMO_TICKS = `RTA_TMO_TICKS
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic [31:0]             reg_rdata,
   // Samples from the fibre link
   input  wire logic               link_valid,
   input  wire rta_pkg::rta_sample_s link_sample,
   // Trip command block
   input  wire logic               trip_block,
   // Evaluated outputs
   output rta_pkg::rta_stat_s      status
);
   localparam int NCH  = `RTA_NCH;
   localparam int NGRP = `RTA_NGRP;
   localparam int NSEN = `RTA_NSEN;
   localparam int NE   = NCH + NGRP;
   localparam int TW   = `RTA_TW;

   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   logic [7:0]    ctrl_q;
   logic [NE-1:0] en_q;
   logic [NE-1:0] alm_en_q;
   logic [21:0]   map_q;
   logic [15:0]   dly_q;
   logic [31:0]   vote_q [2];
   logic [31:0]   thr_q  [NE];

   // -----------------------------------------------------------------
   // Sensor and evaluation state
   // -----------------------------------------------------------------
   logic [TW-1:0]   temp_q [NSEN];
   logic [15:0]     age_q  [NSEN];
   logic [NSEN-1:0] tmo_q;
   logic [15:0]     tick_cnt_q;
   logic            tick_q;
   logic [NE-1:0]   alm_q;
   logic [NE-1:0]   trip_q;
   logic [TW-1:0]   etemp  [NE];
   logic [NE-1:0]   etmo;
   logic [NE-1:0]   eact;
   logic [TW-1:0]   gtemp  [NGRP];
   logic [NGRP-1:0] gtmo;
   logic [1:0]      vhit;
   logic [31:0]     rd_val;
   logic            mod_on;
   logic [3:0]      pg_idx;
   logic [NGRP-1:0] grp_pres;

   assign mod_on = ctrl_q[`RTA_CTRL_ON];
   assign grp_pres = ctrl_q[`RTA_CTRL_PRES];
   assign pg_idx = reg_addr[5:2];

   // Drop test: t below 0.99 * thr, done in integers to avoid a divider
   function automatic logic below_drop(input logic [TW-1:0] t, input logic [TW-1:0] thr);
      logic [22:0] lhs;
      logic [22:0] rhs;
      lhs = 23'({7'h00, t}) * `RTA_DROP_DEN;
      rhs = 23'({7'h00, thr}) * `RTA_DROP_NUM;
      return lhs < rhs;
   endfunction

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   // Software writes; unmapped addresses are ignored
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_q   <= `RTA_CTRL_RST;
         en_q     <= `RTA_EN_RST;
         alm_en_q <= `RTA_EN_RST;
         map_q    <= `RTA_MAP_RST;
         dly_q    <= `RTA_DLY_RST;
         for (int v = 0; v < 2; v++) begin
            vote_q[v] <= `RTA_VOTE_RST;
         end
         for (int e = 0; e < NE; e++) begin
            thr_q[e] <= `RTA_THR_RST;
         end
      end else if (reg_wr) begin
         case (reg_addr)
            `RTA_A_CTRL:    ctrl_q   <= reg_wdata[7:0];
            `RTA_A_CH_EN:   en_q     <= reg_wdata[NE-1:0];
            `RTA_A_ALM_EN:  alm_en_q <= reg_wdata[NE-1:0];
            `RTA_A_GRP_MAP: map_q    <= reg_wdata[21:0];
            `RTA_A_ALM_DLY: dly_q    <= reg_wdata[15:0];
            `RTA_A_VOTE0:   vote_q[0] <= reg_wdata;
            `RTA_A_VOTE1:   vote_q[1] <= reg_wdata;
            default: begin
               if (reg_addr[7:6] == `RTA_PG_THR && pg_idx < 4'(NE)) begin
                  thr_q[pg_idx] <= reg_wdata;
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Register reads
   // -----------------------------------------------------------------
   // Read mux; unmapped words read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (reg_addr)
         `RTA_A_CTRL:    rd_val = {24'h00_0000, ctrl_q};
         `RTA_A_CH_EN:   rd_val = 32'(en_q);
         `RTA_A_ALM_EN:  rd_val = 32'(alm_en_q);
         `RTA_A_GRP_MAP: rd_val = 32'(map_q);
         `RTA_A_ALM_DLY: rd_val = 32'(dly_q);
         `RTA_A_VOTE0:   rd_val = vote_q[0];
         `RTA_A_VOTE1:   rd_val = vote_q[1];
         `RTA_A_ST_ALM:  rd_val = 32'(alm_q);
         `RTA_A_ST_TRIP: rd_val = 32'(trip_q);
         `RTA_A_ST_TMO:  rd_val = 32'(etmo);
         default: begin
            if (reg_addr[7:6] == `RTA_PG_THR && pg_idx < 4'(NE)) begin
               rd_val = thr_q[pg_idx];
            end else if (reg_addr[7:6] == `RTA_PG_TEMP && pg_idx < 4'(NSEN)) begin
               rd_val = 32'(temp_q[pg_idx]);
            end
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // Link demultiplex and supervision
   // -----------------------------------------------------------------
   // Millisecond tick shared by alarm delays and timeouts
   always_ff @(posedge core_clk) begin
      if (rst || tick_cnt_q == 16'(TICK_CYC - 1)) begin
         tick_cnt_q <= 16'h0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == 16'(TICK_CYC - 1));
      end
   end

   generate
      for (genvar s = 0; s < NSEN; s++) begin : g_sen
         always_ff @(posedge core_clk) begin
            if (rst) begin
               temp_q[s] <= '0;
            end else if (link_valid && link_sample.chan == 4'(s)) begin
               temp_q[s] <= link_sample.temp;
            end
         end

         // per-sensor supervision; a fresh sample beats expiry
         always_ff @(posedge core_clk) begin
            if (rst || (link_valid && link_sample.chan == 4'(s))) begin
               age_q[s] <= 16'h0000;
               tmo_q[s] <= 1'b0;
            end else if (tick_q && !tmo_q[s]) begin
               if (age_q[s] == 16'(TMO_TICKS - 1)) begin
                  tmo_q[s] <= 1'b1;
               end
               age_q[s] <= age_q[s] + 16'h0001;
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Groups
   // -----------------------------------------------------------------
   // hottest member, any member timed out
   always_comb begin
      for (int g = 0; g < NGRP; g++) begin
         gtemp[g] = '0;
         gtmo[g]  = 1'b0;
         for (int c = 0; c < NCH; c++) begin
            if (en_q[c] && map_q[2*c +: 2] == 2'(g)) begin
               if (temp_q[c] > gtemp[g]) begin
                  gtemp[g] = temp_q[c];
               end
               gtmo[g] = gtmo[g] | tmo_q[c];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Element evaluation: channels, then groups
   // -----------------------------------------------------------------
   generate
      for (genvar e = 0; e < NE; e++) begin : g_elem
         if (e < NCH) begin : g_ch
            assign etemp[e] = temp_q[e];
            assign eact[e]  = mod_on & en_q[e];
            assign etmo[e]  = eact[e] & tmo_q[e];
         end else begin : g_grp
            // group present only in the configured variant
            assign etemp[e] = gtemp[e-NCH];
            assign eact[e]  = mod_on & en_q[e] & grp_pres[e-NCH];
            assign etmo[e]  = eact[e] & gtmo[e-NCH];
         end

         always_ff @(posedge core_clk) begin
            if (rst || !eact[e]) begin
               trip_q[e] <= 1'b0;
            end else if (etemp[e] >= thr_q[e][`RTA_THR_TRIP]) begin
               trip_q[e] <= 1'b1;
            end else if (below_drop(etemp[e], thr_q[e][`RTA_THR_TRIP])) begin
               trip_q[e] <= 1'b0;
            end
         end

         // delayed alarm; timer held clear below threshold
         logic [15:0] dcnt_q;
         always_ff @(posedge core_clk) begin
            if (rst || !eact[e] || !alm_en_q[e]) begin
               dcnt_q   <= 16'h0000;
               alm_q[e] <= 1'b0;
            end else if (etemp[e] >= thr_q[e][`RTA_THR_ALM]) begin
               if (dcnt_q >= dly_q) begin
                  alm_q[e] <= 1'b1;
               end else if (tick_q) begin
                  dcnt_q <= dcnt_q + 16'h0001;
               end
            end else begin
               dcnt_q <= 16'h0000;
               if (below_drop(etemp[e], thr_q[e][`RTA_THR_ALM])) begin
                  alm_q[e] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Voting
   // -----------------------------------------------------------------
   // count compared in the same cycle as the trip state
   always_comb begin
      logic [3:0] n;
      n = 4'h0;
      for (int v = 0; v < 2; v++) begin
         n = 4'h0;
         for (int c = 0; c < NCH; c++) begin
            if (vote_q[v][c] && en_q[c] && mod_on && trip_q[c]) begin
               n = n + 4'h1;
            end
         end
         // count reached; a zero count never trips
         vhit[v] = vote_q[v][`RTA_VOTE_ON] && vote_q[v][`RTA_VOTE_CNT] != 4'h0
                   && n >= vote_q[v][`RTA_VOTE_CNT];
      end
   end

   // -----------------------------------------------------------------
   // Output register
   // -----------------------------------------------------------------
   // Every output from a flop; block gating stays out of the state so
   // trips reappear at once when the block is released
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status <= '0;
      end else begin
         status.alarm     <= alm_q;
         status.tmo       <= etmo;
         status.trip      <= trip_block ? '0 : trip_q;
         status.vote_trip <= trip_block ? 2'b00 : vhit;
         status.any_alarm <= |alm_q[NE-1:NCH];
         status.any_tmo   <= |etmo[NE-1:NCH];
         status.any_trip  <= !trip_block && |trip_q[NE-1:NCH];
         status.coll_tmo  <= |etmo;
         status.final_trip <= !trip_block && (ctrl_q[`RTA_CTRL_SEL] ? |vhit
                                                                : |trip_q[NCH-1:0]);
      end
   end
endmodule

/* hdl/rta_regs.svh */
// Register map, field positions, reset values and timing figures of the trip block
`ifndef RTA_REGS_SVH
`define RTA_REGS_SVH
// -----------------------------------------------------------------
// Sizes
// -----------------------------------------------------------------
`define RTA_NCH        11
`define RTA_NGRP       4
`define RTA_NSEN       12
`define RTA_TW         16
// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define RTA_CLK_HZ     25000000
`define RTA_TICK_US    1000
`define RTA_TMO_TICKS  1000
// Dropout ratio 0.99 as a fraction
`define RTA_DROP_NUM   23'h0063
`define RTA_DROP_DEN   23'h0064
// -----------------------------------------------------------------
// Byte addresses
// -----------------------------------------------------------------
`define RTA_A_CTRL     8'h00
`define RTA_A_CH_EN    8'h04
`define RTA_A_ALM_EN   8'h08
`define RTA_A_GRP_MAP  8'h0c
`define RTA_A_ALM_DLY  8'h10
`define RTA_A_VOTE0    8'h14
`define RTA_A_VOTE1    8'h18
`define RTA_A_ST_ALM   8'h1c
`define RTA_A_ST_TRIP  8'h20
`define RTA_A_ST_TMO   8'h24
`define RTA_PG_THR     2'h1
`define RTA_PG_TEMP    2'h2
// -----------------------------------------------------------------
// Fields
// -----------------------------------------------------------------
`define RTA_CTRL_ON    0
`define RTA_CTRL_SEL   1
`define RTA_CTRL_PRES  7:4
`define RTA_THR_ALM    15:0
`define RTA_THR_TRIP   31:16
`define RTA_VOTE_MASK  10:0
`define RTA_VOTE_CNT   19:16
`define RTA_VOTE_ON    24
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define RTA_CTRL_RST   8'h00
`define RTA_EN_RST     15'h0000
`define RTA_MAP_RST    22'h00_0000
`define RTA_DLY_RST    16'h0000
`define RTA_VOTE_RST   32'h0000_0000
`define RTA_THR_RST    32'hffff_ffff
`endif

/* hdl/rta_pkg.sv */
// Types shared by the temperature trip block
package rta_pkg;
`include "rta_regs.svh"
   // One demultiplexed reading from the fibre link
   typedef struct packed {
      logic [3:0]             chan;
      logic [`RTA_TW-1:0]     temp;
   } rta_sample_s;

   // All evaluated outputs, elements 0..10 channels, 11..14 groups
   typedef struct packed {
      logic [`RTA_NCH+`RTA_NGRP-1:0] alarm;
      logic [`RTA_NCH+`RTA_NGRP-1:0] trip;
      logic [`RTA_NCH+`RTA_NGRP-1:0] tmo;
      logic                          any_alarm;
      logic                          any_tmo;
      logic                          any_trip;
      logic [1:0]                    vote_trip;
      logic                          coll_tmo;
      logic                          final_trip;
   } rta_stat_s;
endpackage

/* verification/rta_top_assertions.sv */
// Port-level assertions for the temperature trip block
`timescale 1ns/1ns
module rta_top_assertions (
   // Clock and reset
   input wire logic                 core_clk,
   input wire logic                 rst,
   // Register port
   input wire logic [7:0]           reg_addr,
   input wire logic [31:0]          reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [31:0]          reg_rdata,
   // Link and block
   input wire logic                 link_valid,
   input wire rta_pkg::rta_sample_s link_sample,
   input wire logic                 trip_block,
   // Evaluated outputs
   input wire rta_pkg::rta_stat_s   status
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // ------------------------------------------------
   // Causes of a rising channel 0 trip
   // ------------------------------------------------
   // Reading or config write reaches status two to three edges later
   sequence s_new_input;
      $past(link_valid && link_sample.chan == 4'h0, 3) || $past(reg_wr, 3) || $past(reg_wr, 2);
   endsequence
   // A released block only shows after the status flop
   sequence s_unblock;
      $past(trip_block, 2);
   endsequence

   // ------------------------------------------------
   // Checks
   // ------------------------------------------------
   AST_TRIP_CAUSE: assert property ($rose(status.trip[0]) |-> s_new_input or s_unblock)
      else $error("channel trip rose without a cause");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   AST_ANY_ALARM: assert property (status.any_alarm == (|status.alarm[14:11]))
      else $error("combined alarm differs from groups");
   AST_ANY_TRIP: assert property (status.any_trip == (|status.trip[14:11]))
      else $error("combined trip differs from groups");
   AST_ANY_TMO: assert property (status.any_tmo == (|status.tmo[14:11]))
      else $error("combined timeout differs from groups");
   AST_COLL_TMO: assert property (status.coll_tmo == (|status.tmo))
      else $error("collective timeout differs from sources");
   AST_FINAL_SRC: assert property (status.final_trip |-> (|status.trip[10:0]))
      else $error("final trip without any channel trip");
   AST_BLOCK: assert property (trip_block |=> status.trip == '0 && !status.final_trip
      && status.vote_trip == 2'b00 && !status.any_trip)
      else $error("trip output while blocked");
   AST_VOTE_SRC: assert property (|status.vote_trip |-> (|status.trip[10:0]))
      else $error("voting trip without tripping channel");
   AST_RESET_CLEAR: assert property ($fell(rst) |-> status == '0
      && reg_rdata == 32'h0000_0000)
      else $error("outputs not cleared by reset");
endmodule

bind rta_top rta_top_assertions u_checks (
   .core_clk    (core_clk),
   .rst         (rst),
   .reg_addr    (reg_addr),
   .reg_wdata   (reg_wdata),
   .reg_wr      (reg_wr),
   .reg_rd      (reg_rd),
   .reg_rdata   (reg_rdata),
   .link_valid  (link_valid),
   .link_sample (link_sample),
   .trip_block  (trip_block),
   .status      (status)
);

/* verification/rta_remote.sv */
// Behavioural remote sensor unit streaming readings over the link
`timescale 1ns/1ns
module rta_remote (
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst,
   // Scene from the bench
   input wire logic [11:0][15:0]     temps,
   input wire logic                  stall,
   // Link towards the device
   output logic                      link_valid,
   output rta_pkg::rta_sample_s      link_sample
);
   logic [3:0] idx_q;
   logic       gap_q;

   // Round robin, one reading every second cycle; a stall models a dead link
   // twelve sensors multiplexed
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx_q <= 4'h0;
         gap_q <= 1'b0;
         link_valid <= 1'b0;
         link_sample <= '0;
      end else if (stall || !gap_q) begin
         gap_q <= ~gap_q;
         link_valid <= 1'b0;
         link_sample <= ~link_sample; // Idle cycles carry the last reading inverted, so a stall alternates it with the stale value
      end else begin
         gap_q <= 1'b0;
         link_valid <= 1'b1;
         link_sample.chan <= idx_q;
         link_sample.temp <= temps[idx_q];
         idx_q <= (idx_q == 4'hb) ? 4'h0 : idx_q + 4'h1;
      end
   end
endmodule

/* verification/tb_rtd_alarm_trip_aggregation.sv */
// Self-checking bench for the temperature trip block
`timescale 1ns/1ns
module tb_rtd_alarm_trip_aggregation;
   logic                 core_clk = 1'b0;
   logic                 rst = 1'b1;
   logic [7:0]           reg_addr = 8'h00;
   logic [31:0]          reg_wdata = 32'h0000_0000;
   logic                 reg_wr = 1'b0;
   logic                 reg_rd = 1'b0;
   logic [31:0]          reg_rdata;
   logic                 link_valid;
   rta_pkg::rta_sample_s link_sample;
   logic                 trip_block = 1'b0;
   rta_pkg::rta_stat_s   status;
   logic [11:0][15:0]    temps = '0;
   logic                 stall = 1'b0;
   int                   error_cnt = 0;
   int                   n_checks = 0;

   // Short tick and timeout keep the run brief
   rta_top #(.TICK_CYC(10), .TMO_TICKS(4)) dut (
      .core_clk    (core_clk),
      .rst         (rst),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .reg_rdata   (reg_rdata),
      .link_valid  (link_valid),
      .link_sample (link_sample),
      .trip_block  (trip_block),
      .status      (status)
   );
   rta_remote u_remote (
      .core_clk    (core_clk),
      .rst         (rst),
      .temps       (temps),
      .stall       (stall),
      .link_valid  (link_valid),
      .link_sample (link_sample)
   );

   // 25 MHz clock
   always #20 core_clk = ~core_clk;

   // ------------------------------------------------
   // Tasks; wt, wr, rd and blk start on a rising edge, end mid-cycle
   // ------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(negedge core_clk);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(nm, exp, reg_rdata);
   endtask
   task automatic blk(input logic v);
      @(posedge core_clk);
      trip_block <= v;
      wt(1);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ------------------------------------------------
   // Test sequence
   // ------------------------------------------------
   initial begin
      temps[11] = 16'd77;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      wt(1);
      chk("status", 0, status);
      rd(8'h40, 32'hffff_ffff, "thr0");
      rd(8'h3c, 32'h0000_0000, "unmapped");
      wr(8'h00, 32'h0000_00f1);
      rd(8'h00, 32'h0000_00f1, "ctrl");
      wr(8'h04, 32'h0000_7fff);
      wr(8'h08, 32'h0000_7fff);
      wr(8'h0c, 32'h003f_5000);
      wr(8'h10, 32'h0000_0003);
      // Trip 200 and alarm 100 everywhere; the winding group trips at 300
      for (int e = 0; e < 15; e++) begin
         wr(8'h40 + 8'(4 * e), (e == 11) ? 32'h012c_0064 : 32'h00c8_0064);
      end
      // Trip is immediate, alarm waits the delay, group uses its own threshold
      temps[0] = 16'd250;
      for (int i = 0; i < 40 && status.trip[0] !== 1'b1; i++) wt(1);
      chk("trip0", 1, status.trip[0]);
      chk("alarm0 early", 0, status.alarm[0]);
      chk("grp trip", 0, status.trip[11]);
      chk("final", 1, status.final_trip);
      wt(60);
      chk("alarm0", 1, status.alarm[0]);
      chk("any alarm", 1, status.any_alarm);
      temps[1] = 16'd310;
      wt(30);
      chk("grp hottest", 1, status.trip[11]);
      chk("any trip", 1, status.any_trip);
      // Dropout at 0.99 of the trip threshold
      temps[1] = 16'd50;
      temps[0] = 16'd198;
      wt(30);
      chk("hold 198", 1, status.trip[0]);
      temps[0] = 16'd197;
      wt(30);
      chk("drop 197", 0, status.trip[0]);
      // Voting path, count boundary and qualification
      temps[0] = 16'd250;
      wr(8'h00, 32'h0000_00f3);
      wr(8'h14, 32'h0102_0003);
      wr(8'h18, 32'h0103_0007);
      wt(30);
      chk("vote one", 0, {status.vote_trip, status.final_trip});
      temps[1] = 16'd250;
      wt(30);
      chk("vote two", 3'b011, {status.vote_trip, status.final_trip});
      wr(8'h04, 32'h0000_7ffd);
      wt(2);
      chk("vote off", 0, status.vote_trip);
      wr(8'h04, 32'h0000_7fff);
      wt(30);
      // Block suppresses trips but not alarms
      blk(1'b1);
      chk("blk trips", 0, {status.trip, status.vote_trip, status.final_trip});
      chk("blk alarm", 1, status.alarm[0]);
      blk(1'b0);
      // Silent link makes every member time out
      stall = 1'b1;
      wt(80);
      chk("tmo", 5'b11111, {status.tmo[0], status.tmo[11], status.any_tmo, status.coll_tmo,
         status.tmo[14]});
      stall = 1'b0;
      wt(40);
      chk("tmo clear", 0, status.coll_tmo);
      // Absent winding group and a disabled channel alarm both go quiet
      wr(8'h00, 32'h0000_00e3);
      wr(8'h08, 32'h0000_7ffe);
      wt(2);
      chk("grp absent", 0, {status.alarm[11], status.alarm[0], status.any_alarm});
      rd(8'h80, 32'h0000_00fa, "temp0");
      rd(8'hac, 32'h0000_004d, "temp11");
      report_and_stop();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge core_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
